// [rtl/ptg_top.sv]
// pause-trigger gating for ao, ai scan, counter input, pulse train, edges
// assumes all inputs synchronous to mclk_in except pause_trig_in
// Notes on behaviour
// [RULE1] ao updates stop the moment pause asserts
// [RULE2] internal clock: restart right at release
// [RULE3] external clock: restart after release plus edge
// [RULE4] option forces external-style resume on internal
// [RULE5] pulse train freezes at once on pause
// [RULE6] paused phase lengthened by pause duration
// [RULE7] pulse counters kept, resume interrupted phase
// [RULE8] edge counter ignores edges while paused
// [RULE9] counter-input sampling suspends immediately on pause
// [RULE10] internal clock: resume after leftover period
// [RULE11] ci edge counting paused by count gate
// [RULE12] ai scan finishes current channels before halting
// [RULE13] internal clock: ai restarts right at release
// [RULE14] pause is a level, synchronised twice
// [RULE15] setting selects internal or external sample clock
`timescale 1ns/1ps
module ptg_top #(
  parameter int unsigned NUM_CHAN = 4
) (
  input  wire logic                   mclk_in,
  input  wire logic                   rst_in,
  input  wire logic                   pause_trig_in,
  input  wire logic                   clk_src_ext_in,
  input  wire logic                   force_ext_resume_in,
  input  wire logic                   samp_edge_in,
  input  wire logic                   ai_conv_tick_in,
  input  wire logic [ptg_pkg::PER_W-1:0] ci_period_in,
  input  wire logic [ptg_pkg::PER_W-1:0] pulse_hi_in,
  input  wire logic [ptg_pkg::PER_W-1:0] pulse_lo_in,
  input  wire logic                   pulse_en_in,
  input  wire logic                   cnt_src_edge_in,
  input  wire logic                   edge_count_gate_in,
  input  wire logic                   cnt_clear_in,
  output logic                        ao_update_out,
  output logic                        ai_convert_out,
  output logic [ptg_pkg::CHAN_W-1:0]  ai_chan_out,
  output logic                        ai_paused_out,
  output logic                        ci_sample_out,
  output logic                        pulse_out,
  output logic [ptg_pkg::CNT_W-1:0]   edge_count_out,
  output logic [ptg_pkg::CNT_W-1:0]   ci_edge_count_out,
  output logic                        pause_sync_out
);
  import ptg_pkg::*;

  // refuse channel counts that the channel field cannot hold
  if (NUM_CHAN < 1 || NUM_CHAN > (1 << CHAN_W)) begin : g_bad_chan
    $error("ptg_top: NUM_CHAN out of range");
  end

  typedef struct packed {
    ptg_ai_t            ai_st;
    logic [CHAN_W-1:0]  ai_chan;
    logic               ai_conv;
    logic               ao_upd;
    logic               ci_samp;
    logic [PER_W-1:0]   ci_cnt;
    logic               ci_wait;
    logic               pt_lvl;
    logic [PER_W-1:0]   pt_cnt;
    logic [CNT_W-1:0]   ecnt;
    logic [CNT_W-1:0]   ci_ecnt;
  } ptg_state_t;

  ptg_state_t s_q;
  ptg_state_t s_d;

  logic pause;
  logic wait_edge;
  logic ao_run;
  logic ai_run;
  logic ci_run_ext;

  // pause pin sampled through two flops before any gating; see [RULE14]
  ptg_sync u_sync (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .level_in (pause_trig_in),
    .level_out(pause)
  );

  // clock source picks resume style; option forces edge wait; see [RULE15]
  assign wait_edge = clk_src_ext_in | force_ext_resume_in; // see [RULE4]

  ptg_resume u_ao_gate (
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .pause_in    (pause),
    .wait_edge_in(wait_edge),
    .samp_edge_in(samp_edge_in),
    .run_out     (ao_run)
  );

  ptg_resume u_ci_gate (
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .pause_in    (pause),
    .wait_edge_in(1'b1),
    .samp_edge_in(samp_edge_in),
    .run_out     (ci_run_ext)
  );

  // ai shares the resume policy but halts only between scans
  ptg_resume u_ai_gate (
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .pause_in    (pause),
    .wait_edge_in(wait_edge),
    .samp_edge_in(samp_edge_in),
    .run_out     (ai_run)
  );

  always_comb begin
    s_d = s_q;
    // ao: update only on sample edges while running; see [RULE1] [RULE2]
    s_d.ao_upd = samp_edge_in & ao_run; // see [RULE3]

    // ai scan: a started scan always completes; see [RULE12]
    s_d.ai_conv = 1'b0;
    unique case (s_q.ai_st)
      PTG_AI_IDLE, PTG_AI_HELD: begin
        // restart straight at release on internal clock; see [RULE13]
        if (samp_edge_in && ai_run) begin
          s_d.ai_st   = PTG_AI_SCAN;
          s_d.ai_chan = '0;
        end else if (pause) begin
          s_d.ai_st = PTG_AI_HELD;
        end else begin
          s_d.ai_st = PTG_AI_IDLE;
        end
      end
      PTG_AI_SCAN: begin
        if (ai_conv_tick_in) begin
          s_d.ai_conv = 1'b1;
          if (s_q.ai_chan == CHAN_W'(NUM_CHAN - 1)) begin
            s_d.ai_st = pause ? PTG_AI_HELD : PTG_AI_IDLE;
          end else begin
            s_d.ai_chan = s_q.ai_chan + 1'b1;
          end
        end
      end
      default: s_d.ai_st = PTG_AI_IDLE;
    endcase

    // ci sampling: internal clock runs its own period counter
    s_d.ci_samp = 1'b0;
    if (clk_src_ext_in) begin
      s_d.ci_samp = samp_edge_in & ci_run_ext; // see [RULE3]
      s_d.ci_cnt  = '0;
    end else if (!pause) begin
      // counter frozen in pause so only the leftover remains; see [RULE10]
      if (s_q.ci_cnt + 1'b1 >= ci_period_in) begin
        s_d.ci_cnt  = '0;
        s_d.ci_samp = 1'b1;
      end else begin
        s_d.ci_cnt = s_q.ci_cnt + 1'b1;
      end
    end
    if (pause) s_d.ci_samp = 1'b0; // see [RULE9]

    // pulse train: freeze level and count while paused; see [RULE5]
    if (!pulse_en_in) begin
      s_d.pt_lvl = 1'b0;
      s_d.pt_cnt = '0;
    end else if (!pause) begin
      // counters untouched in pause, so the phase just stretches
      if (s_q.pt_cnt + 1'b1 >=
          (s_q.pt_lvl ? pulse_hi_in : pulse_lo_in)) begin // see [RULE7]
        s_d.pt_lvl = ~s_q.pt_lvl;
        s_d.pt_cnt = '0;
      end else begin
        s_d.pt_cnt = s_q.pt_cnt + 1'b1; // see [RULE6]
      end
    end

    // edge counting keeps its value across pauses; see [RULE8]
    if (cnt_clear_in) begin
      s_d.ecnt    = '0;
      s_d.ci_ecnt = '0;
    end else begin
      if (cnt_src_edge_in && !pause) s_d.ecnt = s_q.ecnt + 1'b1;
      // ci modules use the dedicated gate, not pause; see [RULE11]
      if (cnt_src_edge_in && edge_count_gate_in)
        s_d.ci_ecnt = s_q.ci_ecnt + 1'b1;
    end
    s_d.ci_wait = pause;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s_q <= '{ai_st: PTG_AI_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // pause gates the registered ao and ci strobes combinationally, so no stray
  // update slips out in the first paused cycle
  assign ao_update_out     = s_q.ao_upd & ~pause; // see [RULE1]
  assign ai_convert_out    = s_q.ai_conv;
  assign ai_chan_out       = s_q.ai_chan;
  assign ai_paused_out     = (s_q.ai_st == PTG_AI_HELD);
  assign ci_sample_out     = s_q.ci_samp & ~pause; // see [RULE9]
  assign pulse_out         = s_q.pt_lvl;
  assign edge_count_out    = s_q.ecnt;
  assign ci_edge_count_out = s_q.ci_ecnt;
  assign pause_sync_out    = pause;

  a_ao_stops_now: assert property (@(posedge mclk_in) disable iff (rst_in)
    pause |-> !ao_update_out) // see [RULE1]
    else $error("ao update during pause");
  a_ao_ext_wait: assert property (@(posedge mclk_in) disable iff (rst_in)
    (wait_edge && $fell(pause) && !samp_edge_in) |=> !ao_update_out)
    else $error("ao resumed without edge"); // see [RULE3]
  a_ao_int_fast: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!wait_edge && !pause && samp_edge_in) |=>
      (ao_update_out || pause))
    else $error("ao did not resume"); // see [RULE2]
  a_pulse_frozen: assert property (@(posedge mclk_in) disable iff (rst_in)
    (pause && pulse_en_in) |=> $stable(pulse_out) && $stable(s_q.pt_cnt))
    else $error("pulse moved in pause"); // see [RULE5]
  a_edges_ignored: assert property (@(posedge mclk_in) disable iff (rst_in)
    (pause && !cnt_clear_in) |=> $stable(edge_count_out))
    else $error("edge counted in pause"); // see [RULE8]
  a_edges_count: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!pause && cnt_src_edge_in && !cnt_clear_in) |=>
      edge_count_out == $past(edge_count_out) + 1'b1)
    else $error("edge missed"); // see [RULE8]
  a_ci_suspend: assert property (@(posedge mclk_in) disable iff (rst_in)
    pause |-> !ci_sample_out) // see [RULE9]
    else $error("ci sample in pause");
  a_ci_leftover: assert property (@(posedge mclk_in) disable iff (rst_in)
    (pause && !clk_src_ext_in) |=> $stable(s_q.ci_cnt) || clk_src_ext_in)
    else $error("ci period lost"); // see [RULE10]
  a_ci_gate: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!edge_count_gate_in && !cnt_clear_in) |=> $stable(ci_edge_count_out))
    else $error("ci counted with gate low"); // see [RULE11]
  a_ai_finish: assert property (@(posedge mclk_in) disable iff (rst_in)
    (s_q.ai_st == PTG_AI_SCAN && pause && !ai_conv_tick_in) |=>
      s_q.ai_st == PTG_AI_SCAN)
    else $error("scan cut short"); // see [RULE12]

  c_pause_resume: cover property (@(posedge mclk_in) disable iff (rst_in)
    $fell(pause) ##[1:20] ao_update_out);
  c_scan_pause: cover property (@(posedge mclk_in) disable iff (rst_in)
    (s_q.ai_st == PTG_AI_SCAN && pause) ##[1:20] ai_paused_out);
  c_pulse_stretch: cover property (@(posedge mclk_in) disable iff (rst_in)
    (pulse_out && pause) [*3]);
endmodule

// [rtl/ptg_pkg.sv]
// package for the pause-trigger gating block: modes and timing constants
// assumes one 200 MHz clock and synchronous active-high reset
package ptg_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SYNC_STAGES   = 2;
  localparam int unsigned CNT_W         = 32;
  localparam int unsigned PER_W         = 16;
  localparam int unsigned CHAN_W        = 4;
  localparam logic        SRC_INTERNAL  = 1'b0;
  localparam logic        SRC_EXTERNAL  = 1'b1;
  localparam logic [15:0] RST_PULSE_HI  = 16'h0004;
  localparam logic [15:0] RST_PULSE_LO  = 16'h0004;
  typedef enum logic [1:0] {PTG_RUN, PTG_PAUSED, PTG_WAIT_EDGE} ptg_gate_t;
  typedef enum logic [1:0] {PTG_AI_IDLE, PTG_AI_SCAN, PTG_AI_HELD} ptg_ai_t;
endpackage

// [rtl/ptg_sync.sv]
// two-stage level synchroniser for the pause input
// assumes the input is a level from another source
`timescale 1ns/1ps
module ptg_sync (
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic level_in,
  output logic      level_out
);
  import ptg_pkg::*;
  typedef struct packed {
    logic s1;
    logic s2;
  } ptg_sync_t;
  ptg_sync_t st_q;
  ptg_sync_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = level_in;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // first stage is read only by the second
  assign level_out = st_q.s2;
endmodule

// [rtl/ptg_resume.sv]
// resume gate: run/pause decision for one sample-clocked function
// assumes pause is already synchronised and edge is a one-cycle pulse
`timescale 1ns/1ps
module ptg_resume (
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic pause_in,
  input  wire logic wait_edge_in,
  input  wire logic samp_edge_in,
  output logic      run_out
);
  import ptg_pkg::*;
  typedef struct packed {
    ptg_gate_t st;
  } ptg_resume_t;
  ptg_resume_t r_q;
  ptg_resume_t r_d;

  always_comb begin
    r_d = r_q;
    unique case (r_q.st)
      PTG_RUN:
        if (pause_in) r_d.st = PTG_PAUSED;
      PTG_PAUSED:
        if (!pause_in) r_d.st = wait_edge_in ? PTG_WAIT_EDGE : PTG_RUN;
      PTG_WAIT_EDGE:
        if (pause_in) r_d.st = PTG_PAUSED;
        else if (samp_edge_in) r_d.st = PTG_RUN;
      default: r_d.st = PTG_RUN;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      r_q <= '{st: PTG_RUN};
    end else begin
      r_q <= r_d;
    end
  end

  // stop at once on pause; resume at release, or on the sample edge itself when waiting for one
  assign run_out = !pause_in && ((r_q.st == PTG_RUN) ||
                   (r_q.st == PTG_WAIT_EDGE && samp_edge_in) ||
                   (r_q.st == PTG_PAUSED && !wait_edge_in));
endmodule

// [tb/ptg_src_model.sv]
// model of the far side: pause trigger source and sample clock source
// assumes the bench commands pause level, free-running edges and one-shots
`timescale 1ns/1ps
module ptg_src_model #(
  parameter int unsigned SAMP_DIV = 8
) (
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic pause_req_in,
  input  wire logic samp_en_in,
  input  wire logic shot_in,
  input  wire logic tick_en_in,
  output logic      pause_trig_out,
  output logic      samp_edge_out,
  output logic      conv_tick_out
);
  logic [7:0] div_q;
  logic       gen_q;
  // pause is a plain level, not a pulse
  assign pause_trig_out = pause_req_in;
  // one-cycle edge per sample period, or a commanded one-shot
  assign samp_edge_out  = gen_q | shot_in;
  assign conv_tick_out  = tick_en_in;
  always @(posedge mclk_in) begin
    if (rst_in || !samp_en_in) begin
      div_q <= 8'h00;
      gen_q <= 1'b0;
    end else begin
      div_q <= (div_q == SAMP_DIV - 1) ? 8'h00 : div_q + 8'h01;
      gen_q <= (div_q == SAMP_DIV - 1);
    end
  end
endmodule

// [tb/tb_top.sv]
// self-checking bench for the pause-trigger gating block
// assumes the source model drives pause, sample edges and conversion ticks
`timescale 1ns/1ps
module tb_top;
  import ptg_pkg::*;
  localparam int NCH = 4;
  typedef struct {logic p; logic g; int ec; int ci;} ptg_row_t;
  ptg_row_t rows [4] = '{'{0, 1, 5, 5}, '{1, 1, 0, 5}, '{0, 0, 5, 0},
                         '{1, 0, 0, 0}};
  logic mclk_in = 0, rst_in = 1, pause_req = 0, samp_en = 0, shot = 0;
  logic tick_en = 0, ext = 0, fext = 0, pen = 0, src = 0, gate = 0, clr = 0;
  logic pause_trig, samp_edge, conv_tick, ao, conv, aip, cis, pls, psync;
  logic [CHAN_W-1:0] chan;
  logic [CNT_W-1:0] ec, cic, ec0, ci0, ec_q;
  logic pz_q = 0, pl_q = 0;
  int error_cnt = 0, samples_checked = 0, n_ao, n_ci, n_cv, n_tg;
  ptg_src_model ptg_src_model_inst (.mclk_in(mclk_in), .rst_in(rst_in),
    .pause_req_in(pause_req), .samp_en_in(samp_en), .shot_in(shot),
    .tick_en_in(tick_en), .pause_trig_out(pause_trig),
    .samp_edge_out(samp_edge), .conv_tick_out(conv_tick));
  ptg_top #(.NUM_CHAN(NCH)) ptg_top_inst (.mclk_in(mclk_in), .rst_in(rst_in),
    .pause_trig_in(pause_trig), .clk_src_ext_in(ext),
    .force_ext_resume_in(fext), .samp_edge_in(samp_edge),
    .ai_conv_tick_in(conv_tick), .ci_period_in(16'h0008),
    .pulse_hi_in(16'h0003), .pulse_lo_in(16'h0005), .pulse_en_in(pen),
    .cnt_src_edge_in(src), .edge_count_gate_in(gate), .cnt_clear_in(clr),
    .ao_update_out(ao), .ai_convert_out(conv), .ai_chan_out(chan),
    .ai_paused_out(aip), .ci_sample_out(cis), .pulse_out(pls),
    .edge_count_out(ec), .ci_edge_count_out(cic), .pause_sync_out(psync));
  initial forever #2.5 mclk_in = ~mclk_in;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_sync(input logic v);
    int i;
    for (i = 0; i < 20 && psync !== v; i++) @(negedge mclk_in);
    if (psync !== v) begin
      chk(psync, v);
      print_verdict();
    end
  endtask
  // while paused two edges in a row, ao, ci sample, edge count and pulse may not move
  always @(negedge mclk_in) begin
    if (!rst_in && pz_q && psync) begin
      chk(ao, 1'b0);
      chk(cis, 1'b0);
      chk(ec, ec_q);
      chk(pls, pl_q);
    end
    n_ao += (ao === 1'b1);
    n_ci += (cis === 1'b1);
    n_cv += (conv === 1'b1);
    n_tg += (pls !== pl_q);
    pz_q = psync;
    pl_q = pls;
    ec_q = ec;
  end
  initial begin
    repeat (2) @(negedge mclk_in);
    rst_in = 0;
    chk({ao, conv, aip, cis, pls, psync}, 6'h00);
    chk(ec | cic, 32'h0);
    foreach (rows[r]) begin
      pause_req = rows[r].p;
      gate = rows[r].g;
      wait_sync(rows[r].p);
      repeat (2) @(negedge mclk_in);
      ec0 = ec;
      ci0 = cic;
      repeat (5) begin
        src = 1;
        @(negedge mclk_in);
        src = 0;
        @(negedge mclk_in);
      end
      repeat (3) @(negedge mclk_in);
      chk(ec - ec0, rows[r].ec);
      chk(cic - ci0, rows[r].ci);
    end
    // scan started before the pause is completed on every channel
    pause_req = 0;
    tick_en = 1;
    wait_sync(0);
    n_cv = 0;
    shot = 1;
    @(negedge mclk_in);
    shot = 0;
    @(negedge mclk_in);
    pause_req = 1;
    repeat (30) @(negedge mclk_in);
    chk(n_cv, NCH);
    chk(aip, 1'b1);
    chk(chan, NCH - 1);
    pause_req = 0;
    wait_sync(0);
    n_cv = 0;
    shot = 1;
    @(negedge mclk_in);
    shot = 0;
    repeat (20) @(negedge mclk_in);
    chk(n_cv, NCH);
    // internal, external and forced-external resume, all with live edges
    samp_en = 1;
    pen = 1;
    for (int m = 0; m < 3; m++) begin
      ext = (m == 1);
      fext = (m == 2);
      pause_req = 1;
      wait_sync(1);
      repeat (30) @(negedge mclk_in);
      pause_req = 0;
      wait_sync(0);
      n_ao = 0;
      n_ci = 0;
      n_tg = 0;
      repeat (40) @(negedge mclk_in);
      chk(n_ao != 0, 1'b1);
      chk(n_ci != 0, 1'b1);
      chk(n_tg != 0, 1'b1);
    end
    clr = 1;
    @(negedge mclk_in);
    clr = 0;
    @(negedge mclk_in);
    chk(ec | cic, 32'h0);
    print_verdict();
  end
endmodule
